/* gpio_altfunc_power_control.v */
// twelve-pin gpio unit with alternate functions and power switch control
`include "gpio_alt_defines.vh"
module gpio_altfunc_power_control #(
  parameter [31:0] DEBOUNCE_CYC = `DEBOUNCE_CYC,
  parameter [31:0] DELAY_SHORT_CYC = `DELAY_SHORT_CYC,
  parameter [31:0] DELAY_LONG_CYC = `DELAY_LONG_CYC
) (
  input wire sys_clk,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [15:0] isa_addr,
  input wire isa_ior_n,
  input wire isa_iow_n,
  input wire [7:0] isa_data_in,
  output wire [7:0] isa_data_out,
  output wire isa_data_oe_n,
  input wire [7:0] dev_access,
  input wire [11:0] gpio_in,
  output wire [11:0] gpio_out,
  output wire [11:0] gpio_oe_n,
  input wire multi_use_input_zero,
  input wire companion_wake_input_a,
  input wire companion_wake_input_b,
  output wire main_power_enable_out,
  output wire irq_route_req,
  output wire [3:0] irq_route_level
);
  localparam [2:0] ST_OFF = 3'b001;
  localparam [2:0] ST_ON = 3'b010;
  localparam [2:0] ST_DLY = 3'b100;

  function [11:0] loc_pins;
    input [3:0] c;
    begin
      case (c)
        4'h2: loc_pins = 12'h100;
        4'h4: loc_pins = 12'h200;
        4'h6: loc_pins = 12'h400;
        4'h8: loc_pins = 12'h800;
        4'h1, 4'h3, 4'h5, 4'h7, 4'h9, 4'hB, 4'hD, 4'hF: begin
          loc_pins = 12'h001 << c[3:1];
        end
        default: loc_pins = 12'h000;
      endcase
    end
  endfunction

  function [11:0] ring_pins;
    input [2:0] c;
    begin
      if (c >= 3'h2 && c <= 3'h6) begin
        ring_pins = 12'h001 << c;
      end else begin
        ring_pins = 12'h000;
      end
    end
  endfunction

  reg [7:0] pin_en_lo_ff;
  reg [3:0] pin_en_hi_ff;
  reg [11:0] cs_base_ff [0:2];
  reg [7:0] cs_ctrl_ff [0:2];
  reg [11:0] sio_base_ff;
  reg [7:0] irq_map_ff;
  reg [7:0] pol_lo_ff;
  reg [7:0] func_lo_ff;
  reg [7:0] dir_lo_ff;
  reg [5:0] sio_ctrl_ff;
  reg [7:0] zws_en_ff;
  reg [3:0] pol_hi_ff;
  reg [3:0] func_hi_ff;
  reg [3:0] dir_hi_ff;
  reg [6:0] pwr_pin_ff;
  reg dly_sel_ff;
  reg hold_ff;
  reg soft_off_ff;
  reg [31:0] prdata_ff;
  reg [7:0] rd_val;
  reg hit_reg;
  reg [14:0] s1_ff;
  reg [14:0] s2_ff;
  reg [14:0] s3_ff;
  reg [14:0] filt_ff;
  reg [11:0] sio_data_ff;
  reg [7:0] isa_data_out_ff;
  reg iow_d_ff;
  reg [11:0] gpio_out_ff;
  reg [11:0] gpio_oe_n_ff;
  reg irq_req_ff;
  reg ring_d_ff;
  reg wake_a_d_ff;
  reg wake_b_d_ff;
  reg [31:0] deb_cnt_ff;
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [31:0] tmr_ff;
  reg [31:0] nxt_tmr;
  reg power_ff;

  wire [11:0] pin_en = {pin_en_hi_ff, pin_en_lo_ff};
  wire [11:0] pol = {pol_hi_ff, pol_lo_ff};
  wire [11:0] func = {func_hi_ff, func_lo_ff};
  wire [11:0] dir = {dir_hi_ff, dir_lo_ff};
  wire [11:0] alt_vec = pin_en & ~func;
  wire [11:0] pin_lvl = filt_ff[11:0];

  // apb slave: no wait states, read data latched in the setup cycle
  wire setup = psel & ~penable;
  wire acc = psel & penable;
  wire [8:0] idx = paddr[10:2];
  wire aligned = (paddr[1:0] == 2'b00) & ~paddr[11];
  wire wr = acc & pwrite & aligned & hit_reg;
  wire [7:0] wd = pwdata[7:0];

  assign pready = 1'b1;
  assign pslverr = acc & ~(aligned & hit_reg);
  assign prdata = prdata_ff;

  // reserved bits are simply not stored and read back as zero
  always @* begin
    hit_reg = 1'b1;
    rd_val = 8'h00;
    case (idx)
      `IDX_PIN_EN_LO: rd_val = pin_en_lo_ff;
      `IDX_PIN_EN_HI: rd_val = {4'h0, pin_en_hi_ff};
      `IDX_CS0_MSB: rd_val = {4'h0, cs_base_ff[0][11:8]};
      `IDX_CS0_LSB: rd_val = cs_base_ff[0][7:0];
      `IDX_CS1_MSB: rd_val = {4'h0, cs_base_ff[1][11:8]};
      `IDX_CS1_LSB: rd_val = cs_base_ff[1][7:0];
      `IDX_CS2_MSB: rd_val = {4'h0, cs_base_ff[2][11:8]};
      `IDX_CS2_LSB: rd_val = cs_base_ff[2][7:0];
      `IDX_SIO_MSB: rd_val = {4'h0, sio_base_ff[11:8]};
      `IDX_SIO_LSB: rd_val = sio_base_ff[7:0];
      `IDX_IRQ_MAP: rd_val = irq_map_ff;
      `IDX_POL_LO: rd_val = pol_lo_ff;
      `IDX_CS0_CTRL: rd_val = cs_ctrl_ff[0];
      `IDX_CS1_CTRL: rd_val = cs_ctrl_ff[1];
      `IDX_CS2_CTRL: rd_val = cs_ctrl_ff[2];
      `IDX_FUNC_LO: rd_val = func_lo_ff;
      `IDX_DIR_LO: rd_val = dir_lo_ff;
      `IDX_SIO_CTRL: rd_val = {2'b00, sio_ctrl_ff};
      `IDX_ZWS_EN: rd_val = zws_en_ff;
      `IDX_POL_HI: rd_val = {4'h0, pol_hi_ff};
      `IDX_FUNC_HI: rd_val = {4'h0, func_hi_ff};
      `IDX_DIR_HI: rd_val = {4'h0, dir_hi_ff};
      `IDX_PWR_PIN: rd_val = {1'b0, pwr_pin_ff};
      `IDX_PWR_CTRL: rd_val = {power_ff, hold_ff, 5'h00, dly_sel_ff};
      `IDX_PIN_STAT_LO: rd_val = pin_lvl[7:0];
      `IDX_PIN_STAT_HI: rd_val = {4'h0, pin_lvl[11:8]};
      default: hit_reg = 1'b0;
    endcase
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup) begin
      prdata_ff <= {24'h00_0000, (aligned ? rd_val : 8'h00)};
    end
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_en_lo_ff <= `CFG_RST_BYTE;
      pin_en_hi_ff <= `CFG_RST_NIB;
      cs_base_ff[0] <= `CFG_RST_BASE;
      cs_base_ff[1] <= `CFG_RST_BASE;
      cs_base_ff[2] <= `CFG_RST_BASE;
      cs_ctrl_ff[0] <= `CFG_RST_BYTE;
      cs_ctrl_ff[1] <= `CFG_RST_BYTE;
      cs_ctrl_ff[2] <= `CFG_RST_BYTE;
      sio_base_ff <= `CFG_RST_BASE;
      irq_map_ff <= `CFG_RST_BYTE;
      pol_lo_ff <= `CFG_RST_BYTE;
      func_lo_ff <= `CFG_RST_BYTE;
      dir_lo_ff <= `CFG_RST_BYTE;
      sio_ctrl_ff <= 6'h00;
      zws_en_ff <= `CFG_RST_BYTE;
      pol_hi_ff <= `CFG_RST_NIB;
      func_hi_ff <= `CFG_RST_NIB;
      dir_hi_ff <= `CFG_RST_NIB;
      pwr_pin_ff <= 7'h00;
      dly_sel_ff <= 1'b0;
      hold_ff <= 1'b0;
      soft_off_ff <= 1'b0;
    end else begin
      soft_off_ff <= wr & (idx == `IDX_PWR_CTRL) & wd[`PWR_SOFT_OFF_BIT];
      if (wr) begin
        case (idx)
          `IDX_PIN_EN_LO: pin_en_lo_ff <= wd;
          `IDX_PIN_EN_HI: pin_en_hi_ff <= wd[3:0];
          `IDX_CS0_MSB: cs_base_ff[0][11:8] <= wd[3:0];
          `IDX_CS0_LSB: cs_base_ff[0][7:0] <= wd;
          `IDX_CS1_MSB: cs_base_ff[1][11:8] <= wd[3:0];
          `IDX_CS1_LSB: cs_base_ff[1][7:0] <= wd;
          `IDX_CS2_MSB: cs_base_ff[2][11:8] <= wd[3:0];
          `IDX_CS2_LSB: cs_base_ff[2][7:0] <= wd;
          `IDX_SIO_MSB: sio_base_ff[11:8] <= wd[3:0];
          `IDX_SIO_LSB: sio_base_ff[7:0] <= wd;
          `IDX_IRQ_MAP: irq_map_ff <= wd;
          `IDX_POL_LO: pol_lo_ff <= wd;
          `IDX_CS0_CTRL: cs_ctrl_ff[0] <= wd;
          `IDX_CS1_CTRL: cs_ctrl_ff[1] <= wd;
          `IDX_CS2_CTRL: cs_ctrl_ff[2] <= wd;
          `IDX_FUNC_LO: func_lo_ff <= wd;
          `IDX_DIR_LO: dir_lo_ff <= wd;
          `IDX_SIO_CTRL: sio_ctrl_ff <= wd[5:0];
          `IDX_ZWS_EN: zws_en_ff <= wd;
          `IDX_POL_HI: pol_hi_ff <= wd[3:0];
          `IDX_FUNC_HI: func_hi_ff <= wd[3:0];
          `IDX_DIR_HI: dir_hi_ff <= wd[3:0];
          `IDX_PWR_PIN: pwr_pin_ff <= wd[6:0];
          `IDX_PWR_CTRL: begin
            dly_sel_ff <= wd[`PWR_DLY_SEL_BIT];
            hold_ff <= wd[`PWR_HOLD_BIT];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // pin synchroniser: a level counts once stages two and three agree
  wire [14:0] raw_in = {companion_wake_input_b, companion_wake_input_a,
                        multi_use_input_zero, gpio_in};

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_ff <= `SYNC_RST;
      s2_ff <= `SYNC_RST;
      s3_ff <= `SYNC_RST;
      filt_ff <= `SYNC_RST;
    end else begin
      s1_ff <= raw_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      filt_ff <= (s2_ff & s3_ff) | (filt_ff & (s2_ff ^ s3_ff));
    end
  end

  // isa side runs on sys_clk, so no synchroniser here
  wire ior = ~isa_ior_n;
  wire iow = ~isa_iow_n;
  wire [15:0] sio_base = {4'h0, sio_base_ff};
  wire at_base = (isa_addr == sio_base);
  wire at_next = (isa_addr == sio_base + 16'h0001);
  wire single = sio_ctrl_ff[`SIO_SINGLE_BIT];
  wire grp1 = sio_ctrl_ff[`SIO_GROUP_BIT];
  wire hit1 = single ? (grp1 & at_base) : at_base;
  wire hit2 = single ? (~grp1 & at_base) : at_next;
  wire iow_rise = iow & ~iow_d_ff;
  wire [11:0] sio_rd;

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      iow_d_ff <= 1'b0;
      sio_data_ff <= 12'h000;
      isa_data_out_ff <= 8'h00;
    end else begin
      iow_d_ff <= iow;
      if (iow_rise & hit1) begin
        sio_data_ff[7:0] <= isa_data_in;
      end else if (iow_rise & hit2) begin
        sio_data_ff[11:8] <= isa_data_in[3:0];
      end
      isa_data_out_ff <= hit1 ? sio_rd[7:0] : {4'h0, sio_rd[11:8]};
    end
  end

  assign isa_data_out = isa_data_out_ff;
  assign isa_data_oe_n = ~(ior & (hit1 | hit2));

  // chip-select strobes
  wire [11:0] cs_sel [0:2];
  wire [2:0] cs_act;
  genvar k;
  generate
    for (k = 0; k < 3; k = k + 1) begin : g_cs
      wire [1:0] sz = cs_ctrl_ff[k][7:6];
      wire [1:0] qual = cs_ctrl_ff[k][5:4];
      wire [15:0] msk = 16'hFFFF << sz;
      wire match = ((isa_addr ^ {4'h0, cs_base_ff[k]}) & msk) == 16'h0000;
      assign cs_act[k] = match & ((qual == 2'b00) |
                                  ((qual == 2'b01) & ior) |
                                  ((qual == 2'b10) & iow) |
                                  ((qual == 2'b11) & (ior | iow)));
      assign cs_sel[k] = loc_pins(cs_ctrl_ff[k][3:0]);
    end
  endgenerate

  // zero wait state: gpio device also covers our own ports
  wire gpio_dev = hit1 | hit2 | (|cs_act);
  wire [7:0] dev_all = {dev_access[`ZWS_GPIO_BIT] | gpio_dev,
                        dev_access[6:0]};
  wire zws_act = (ior | iow) & (|(dev_all & zws_en_ff));
  wire [11:0] zws_sel = loc_pins(sio_ctrl_ff[3:0]);
  wire [11:0] por_sel = loc_pins(pwr_pin_ff[3:0]);
  wire [11:0] ring_sel = ring_pins(pwr_pin_ff[6:4]);
  wire [11:0] irq_sel = loc_pins(irq_map_ff[7:4]);
  wire por_act = (state_ff == ST_DLY);
  wire [11:0] nxt_gpio_out;
  wire [11:0] nxt_gpio_oe_n;

  genvar i;
  generate
    for (i = 0; i < 12; i = i + 1) begin : g_pin
      wire sio_ok = pin_en[i] & func[i];
      wire alt_drv = cs_sel[0][i] | cs_sel[1][i] | cs_sel[2][i] |
                     zws_sel[i] | por_sel[i];
      wire alt_low = (cs_sel[0][i] & cs_act[0]) |
                     (cs_sel[1][i] & cs_act[1]) |
                     (cs_sel[2][i] & cs_act[2]) |
                     (zws_sel[i] & zws_act) |
                     (por_sel[i] & por_act);
      assign nxt_gpio_oe_n[i] = ~((sio_ok & ~dir[i]) |
                                  (alt_vec[i] & alt_drv));
      assign nxt_gpio_out[i] = sio_ok ? (sio_data_ff[i] ^ pol[i]) :
                               ~alt_low;
      assign sio_rd[i] = dir[i] ? (pin_lvl[i] ^ pol[i]) :
                         sio_data_ff[i];
    end
  endgenerate

  // ring pin idles high when unplaced; interrupt pin must be an input
  wire ring_n = ~|(ring_sel & alt_vec & ~pin_lvl);
  wire ring_pulse = ring_n & ~ring_d_ff;
  wire nxt_irq = |(irq_sel & alt_vec & dir & pin_lvl);
  wire wake_ev = (filt_ff[13] & ~wake_a_d_ff) |
                 (filt_ff[14] & ~wake_b_d_ff);
  wire sw_low = ~filt_ff[12];
  wire press = sw_low & (deb_cnt_ff == DEBOUNCE_CYC - 32'h1);

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      gpio_out_ff <= 12'hFFF;
      gpio_oe_n_ff <= 12'hFFF;
      irq_req_ff <= 1'b0;
      ring_d_ff <= 1'b1;
      wake_a_d_ff <= 1'b1;
      wake_b_d_ff <= 1'b1;
      deb_cnt_ff <= 32'h0000_0000;
    end else begin
      gpio_out_ff <= nxt_gpio_out;
      gpio_oe_n_ff <= nxt_gpio_oe_n;
      irq_req_ff <= nxt_irq;
      ring_d_ff <= ring_n;
      wake_a_d_ff <= filt_ff[13];
      wake_b_d_ff <= filt_ff[14];
      // saturates so a held switch gives one press only
      if (!sw_low) begin
        deb_cnt_ff <= 32'h0000_0000;
      end else if (deb_cnt_ff != DEBOUNCE_CYC) begin
        deb_cnt_ff <= deb_cnt_ff + 32'h1;
      end
    end
  end

  always @* begin
    nxt_state = state_ff;
    nxt_tmr = tmr_ff;
    case (state_ff)
      ST_OFF: begin
        if (wake_ev | ring_pulse | press) begin
          nxt_state = ST_ON;
        end
      end
      ST_ON: begin
        if (soft_off_ff) begin
          nxt_state = ST_OFF;
        end else if (press) begin
          nxt_state = ST_DLY;
          nxt_tmr = (dly_sel_ff ? DELAY_LONG_CYC : DELAY_SHORT_CYC) -
                    32'h1;
        end
      end
      ST_DLY: begin
        if (soft_off_ff || tmr_ff == 32'h0000_0000) begin
          nxt_state = ST_OFF;
        end else if (!hold_ff) begin
          nxt_tmr = tmr_ff - 32'h1;
        end
      end
      default: nxt_state = ST_OFF;
    endcase
  end

  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_OFF;
      tmr_ff <= 32'h0000_0000;
      power_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      tmr_ff <= nxt_tmr;
      power_ff <= (nxt_state != ST_OFF);
    end
  end

  assign gpio_out = gpio_out_ff;
  assign gpio_oe_n = gpio_oe_n_ff;
  assign main_power_enable_out = power_ff;
  assign irq_route_req = irq_req_ff;
  assign irq_route_level = irq_map_ff[3:0];
endmodule

/* gpio_alt_defines.vh */
// register indices, field positions, reset values and timing constants
`ifndef GPIO_ALT_DEFINES_VH
`define GPIO_ALT_DEFINES_VH
`define IDX_PIN_EN_LO 9'h025
`define IDX_PIN_EN_HI 9'h026
`define IDX_CS0_MSB 9'h060
`define IDX_CS0_LSB 9'h061
`define IDX_CS1_MSB 9'h062
`define IDX_CS1_LSB 9'h063
`define IDX_CS2_MSB 9'h064
`define IDX_CS2_LSB 9'h065
`define IDX_SIO_MSB 9'h066
`define IDX_SIO_LSB 9'h067
`define IDX_IRQ_MAP 9'h070
`define IDX_POL_LO 9'h0F0
`define IDX_CS0_CTRL 9'h0F1
`define IDX_CS1_CTRL 9'h0F2
`define IDX_CS2_CTRL 9'h0F3
`define IDX_FUNC_LO 9'h0F4
`define IDX_DIR_LO 9'h0F5
`define IDX_SIO_CTRL 9'h0F6
`define IDX_ZWS_EN 9'h0F7
`define IDX_POL_HI 9'h0F8
`define IDX_FUNC_HI 9'h0F9
`define IDX_DIR_HI 9'h0FA
`define IDX_PWR_PIN 9'h0FB
`define IDX_PWR_CTRL 9'h100
`define IDX_PIN_STAT_LO 9'h101
`define IDX_PIN_STAT_HI 9'h102
`define SIO_SINGLE_BIT 4
`define SIO_GROUP_BIT 5
`define ZWS_GPIO_BIT 7
`define PWR_DLY_SEL_BIT 0
`define PWR_SOFT_OFF_BIT 5
`define PWR_HOLD_BIT 6
`define PWR_STAT_BIT 7
`define CFG_RST_BYTE 8'h00
`define CFG_RST_NIB 4'h0
`define CFG_RST_BASE 12'h000
`define SYNC_RST 15'h7FFF
`define CLK_HZ 20000000
`define DEBOUNCE_MS 16
`define OFF_DELAY_SHORT_S 5
`define OFF_DELAY_LONG_S 21
`define DEBOUNCE_CYC ((`DEBOUNCE_MS * `CLK_HZ + 999) / 1000)
`define DELAY_SHORT_CYC (`OFF_DELAY_SHORT_S * `CLK_HZ)
`define DELAY_LONG_CYC (`OFF_DELAY_LONG_S * `CLK_HZ)
`endif

/* board_pin_model.sv */
// board side of the pins: external drivers, pull-ups, floating pins
module board_pin_model (
  input wire sys_clk,
  input wire [11:0] gpio_out,
  input wire [11:0] gpio_oe_n,
  input wire [11:0] ext_val,
  input wire [11:0] ext_en,
  output logic [11:0] gpio_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // gpio 4 and 7 lack a pull-up, so undriven they wander
  localparam logic [11:0] pulled = 12'hF6F;
  logic [11:0] wander = 12'h000;
  always @(posedge sys_clk) begin
    wander <= ~wander;
  end
  always_comb begin
    for (int i = 0; i < 12; i++)
      gpio_in[i] = !gpio_oe_n[i] ? gpio_out[i] :
        ext_en[i] ? ext_val[i] : (pulled[i] | wander[i]);
  end
endmodule

/* gpio_alt_props.sv */
// assertion checker on the block ports
module gpio_alt_props #(
  parameter [31:0] DEBOUNCE_CYC = 8,
  parameter [31:0] DELAY_SHORT_CYC = 20,
  parameter [31:0] DELAY_LONG_CYC = 40
) (
  input wire sys_clk,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire isa_ior_n,
  input wire isa_data_oe_n,
  input wire multi_use_input_zero,
  input wire companion_wake_input_a,
  input wire main_power_enable_out
);
  logic [31:0] low_cnt;
  logic on_at_press;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // raw switch low time; the margin covers the input synchroniser
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      low_cnt <= 32'h0;
      on_at_press <= 1'b0;
    end else begin
      low_cnt <= multi_use_input_zero ? 32'h0 : low_cnt + 32'h1;
      if (low_cnt == 32'h0)
        on_at_press <= main_power_enable_out;
    end
  end
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access phase");
  a_misalign_err: assert property (psel && penable && paddr[1:0] != 2'b00
    |-> pslverr) else $error("misaligned access not refused");
  a_rd_upper_zero: assert property (psel && penable && !pwrite
    |-> prdata[31:8] == 24'h0) else $error("read data upper bits set");
  a_soft_off: assert property (psel && penable && pwrite
    && paddr == 12'h400 && pwdata[5] |-> ##[1:2] !main_power_enable_out)
    else $error("software off ignored");
  a_oe_read_only: assert property (!isa_data_oe_n |-> !isa_ior_n)
    else $error("data driven without read strobe");
  a_wake_on: assert property ($rose(companion_wake_input_a)
    && !main_power_enable_out |-> ##[1:10] main_power_enable_out)
    else $error("wake edge did not power on");
  a_switch_on: assert property (low_cnt == DEBOUNCE_CYC + 32'd8
    && !on_at_press |-> main_power_enable_out)
    else $error("held switch did not power on");
  a_stat_read: assert property (psel && !penable && !pwrite
    && paddr == 12'h400 |=> prdata[7] == $past(main_power_enable_out))
    else $error("power status read wrong");
endmodule
bind gpio_altfunc_power_control gpio_alt_props #(
  .DEBOUNCE_CYC(DEBOUNCE_CYC), .DELAY_SHORT_CYC(DELAY_SHORT_CYC),
  .DELAY_LONG_CYC(DELAY_LONG_CYC)) gpio_alt_props_i (.sys_clk, .reset_n,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr, .isa_ior_n,
  .isa_data_oe_n, .multi_use_input_zero, .companion_wake_input_a,
  .main_power_enable_out);

/* tb.sv */
// self-checking bench: registers, simple io, strobes, zero wait, power
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin \
  bad_count++; $display("[FAIL] %s expected %h seen %h", nm, ex, gt); \
  end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic isa_ior_n, isa_iow_n, isa_data_oe_n, sw_n, wake_a, wake_b;
  logic main_pwr, irq_req, err, oe;
  logic [11:0] paddr, ext_val, ext_en, gpio_in, gpio_out, gpio_oe_n;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] isa_addr;
  logic [7:0] isa_data_in, isa_data_out, dev_access, d, p, v;
  logic [3:0] irq_lvl;
  int bad_count, compares, cyc, n;
  localparam logic [8:0] reg_idx [5] = '{9'h0F8, 9'h0F9, 9'h0FA, 9'h0FB,
    9'h0F7};
  localparam logic [7:0] reg_mask [5] = '{8'h0F, 8'h0F, 8'h0F, 8'h7F, 8'hFF};
  // short counts keep the power tests to a few hundred cycles
  gpio_altfunc_power_control #(.DEBOUNCE_CYC(8), .DELAY_SHORT_CYC(20),
    .DELAY_LONG_CYC(40)) gpio_altfunc_power_control_i (.sys_clk, .reset_n,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .isa_addr, .isa_ior_n, .isa_iow_n, .isa_data_in, .isa_data_out,
    .isa_data_oe_n, .dev_access, .gpio_in, .gpio_out, .gpio_oe_n,
    .multi_use_input_zero(sw_n), .companion_wake_input_a(wake_a),
    .companion_wake_input_b(wake_b), .main_power_enable_out(main_pwr),
    .irq_route_req(irq_req), .irq_route_level(irq_lvl));
  board_pin_model board_pin_model_i (.sys_clk, .gpio_out, .gpio_oe_n,
    .ext_val, .ext_en, .gpio_in);
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end
  function automatic logic cs_hit(input logic m, input logic [1:0] q,
    input logic r, input logic w);
    return m && (q == 2'd0 || (q[0] && r) || (q[1] && w));
  endfunction
  task automatic apb(input [11:0] a, input w, input [7:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input [8:0] i, input [7:0] wd);
    apb({1'b0, i, 2'b00}, 1'b1, wd);
  endtask
  task automatic isa(input [15:0] a, input r, input [7:0] wd);
    @(posedge sys_clk);
    isa_addr <= a;
    isa_data_in <= wd;
    isa_ior_n <= !r;
    isa_iow_n <= r;
    repeat (3) @(posedge sys_clk);
    rd = {24'h0, isa_data_out};
    oe = isa_data_oe_n;
    {isa_ior_n, isa_iow_n} <= 2'b11;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic press(input int len);
    @(posedge sys_clk);
    sw_n <= 1'b0;
    repeat (len) @(posedge sys_clk);
    sw_n <= 1'b1;
    repeat (12) @(posedge sys_clk);
  endtask
  task automatic wake(input logic sel);
    @(posedge sys_clk);
    {wake_b, wake_a} <= sel ? 2'b10 : 2'b01;
    repeat (10) @(posedge sys_clk);
    {wake_b, wake_a} <= 2'b00;
    repeat (2) @(posedge sys_clk);
    `CHK("wake on", 1'b1, main_pwr)
  endtask
  initial begin
    reset_n = 1'b0;
    {psel, penable, pwrite, wake_a, wake_b} = 5'h00;
    {isa_ior_n, isa_iow_n, sw_n} = 3'h7;
    {paddr, pwdata, isa_addr, isa_data_in, dev_access} = '0;
    {ext_val, ext_en} = '0;
    void'($urandom(73739));
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb({1'b0, reg_idx[i], 2'b00}, 1'b0, 8'h00);
      `CHK("reset value", 32'h0, rd)
      d = 8'($urandom);
      wr(reg_idx[i], d);
      apb({1'b0, reg_idx[i], 2'b00}, 1'b0, 8'h00);
      `CHK("reserved mask", {24'h0, d & reg_mask[i]}, rd)
      wr(reg_idx[i], 8'h00);
    end
    apb(12'h801, 1'b0, 8'h00);
    `CHK("misaligned refused", 1'b1, err)
    apb(12'h7FC, 1'b1, 8'hFF);
    `CHK("unmapped refused", 1'b1, err)
    $display("test registers done");
    wr(9'h0F4, 8'hFF);
    wr(9'h066, 8'h03);
    isa(16'h0300, 1'b0, 8'h00);
    `CHK("no pin enable", 12'hFFF, gpio_oe_n)
    wr(9'h025, 8'hFF);
    wr(9'h026, 8'h0F);
    d = 8'($urandom);
    p = 8'($urandom);
    wr(9'h0F0, p);
    isa(16'h0300, 1'b0, d);
    `CHK("group1 drive", d ^ p, gpio_out[7:0])
    `CHK("group1 driving", 8'h00, gpio_oe_n[7:0])
    v = 8'($urandom);
    p = 8'($urandom);
    ext_val <= {v[3:0], 8'h00};
    ext_en <= 12'hF00;
    wr(9'h0F9, 8'h0F);
    wr(9'h0FA, 8'h0F);
    wr(9'h0F8, p);
    isa(16'h0301, 1'b1, 8'h00);
    `CHK("group2 read", {4'h0, v[3:0] ^ p[3:0]}, rd[7:0])
    `CHK("read enable", 1'b0, oe)
    `CHK("group2 input", 4'hF, gpio_oe_n[11:8])
    ext_en <= 12'h000;
    wr(9'h0FA, 8'h00);
    isa(16'h0301, 1'b0, v);
    `CHK("group2 drive", v[3:0] ^ p[3:0], gpio_out[11:8])
    wr(9'h0F6, 8'h30);
    isa(16'h0300, 1'b1, 8'h00);
    `CHK("single group1", d, rd[7:0])
    isa(16'h0301, 1'b1, 8'h00);
    `CHK("single no hit", 1'b1, oe)
    wr(9'h0F6, 8'h10);
    isa(16'h0300, 1'b1, 8'h00);
    `CHK("single group2", {4'h0, v[3:0]}, rd[7:0])
    $display("test simple io done");
    wr(9'h0F9, 8'h0E);
    wr(9'h060, 8'h02);
    wr(9'h061, 8'h00);
    for (int s = 0; s < 4; s++)
      for (int q = 0; q < 4; q++) begin
        wr(9'h0F1, {s[1:0], q[1:0], 4'h2});
        for (int o = 0; o < 2; o++) begin
          d = 8'($urandom);
          @(posedge sys_clk);
          isa_addr <= 16'h0200 + (16'd1 << s) - 16'(o == 0);
          {isa_iow_n, isa_ior_n} <= d[1:0];
          repeat (3) @(posedge sys_clk);
          p[0] = !cs_hit(o == 0, q[1:0], !d[0], !d[1]);
          `CHK("strobe", p[0], gpio_out[8])
        end
      end
    {isa_ior_n, isa_iow_n} <= 2'b11;
    `CHK("strobe driving", 1'b0, gpio_oe_n[8])
    $display("test strobes done");
    wr(9'h0F6, 8'h04);
    wr(9'h0F9, 8'h0C);
    d = 8'($urandom);
    wr(9'h0F7, d);
    // zero wait only shows during a host read or write cycle
    for (int b = 0; b < 8; b++) begin
      @(posedge sys_clk);
      dev_access <= 8'h01 << b;
      isa_ior_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      `CHK("zero wait", !d[b], gpio_out[9])
    end
    dev_access <= 8'h00;
    isa_ior_n <= 1'b1;
    $display("test zero wait done");
    wr(9'h0F9, 8'h08);
    wr(9'h0F4, 8'hFB);
    // let the released ring pin settle high, else placing it is an edge
    repeat (8) @(posedge sys_clk);
    wr(9'h0FB, 8'h26);
    `CHK("power off", 1'b0, main_pwr)
    press(5);
    `CHK("short press", 1'b0, main_pwr)
    press(20);
    `CHK("switch on", 1'b1, main_pwr)
    for (int k = 0; k < 2; k++) begin
      wr(9'h100, 8'(k));
      @(posedge sys_clk);
      sw_n <= 1'b0;
      n = 0;
      while (main_pwr === 1'b1 && n < 100) begin
        @(posedge sys_clk);
        n++;
        if (n == 18) `CHK("off request", 1'b0, gpio_out[10])
      end
      sw_n <= 1'b1;
      `CHK("off delay", 1'b1, n >= 28 + 20 * k && n <= 40 + 20 * k)
      wake(k[0]);
    end
    wr(9'h100, 8'h40);
    press(20);
    repeat (60) @(posedge sys_clk);
    `CHK("hold", 1'b1, main_pwr)
    wr(9'h100, 8'h00);
    repeat (30) @(posedge sys_clk);
    `CHK("hold release", 1'b0, main_pwr)
    wake(1'b0);
    apb(12'h400, 1'b0, 8'h00);
    `CHK("power status", 1'b1, rd[7])
    wr(9'h100, 8'h20);
    repeat (3) @(posedge sys_clk);
    `CHK("soft off", 1'b0, main_pwr)
    ext_en <= 12'h004;
    repeat (5) @(posedge sys_clk);
    ext_en <= 12'h000;
    repeat (8) @(posedge sys_clk);
    `CHK("ring on", 1'b1, main_pwr)
    $display("test power done");
    // gpio 11 as alternate input carries a mapped interrupt level
    v = 8'($urandom);
    wr(9'h0F9, 8'h00);
    wr(9'h0FA, 8'h08);
    wr(9'h070, {4'h8, v[3:0]});
    ext_val <= {v[7], 11'h000};
    ext_en <= 12'h800;
    repeat (8) @(posedge sys_clk);
    `CHK("irq level", v[3:0], irq_lvl)
    `CHK("irq pin", v[7], irq_req)
    ext_val <= {~v[7], 11'h000};
    repeat (8) @(posedge sys_clk);
    `CHK("irq pin", ~v[7], irq_req)
    ext_en <= 12'h000;
    $display("test irq map done");
    conclude();
  end
endmodule
